// File: pdc_pkg.sv
// Shared constants for the loop divider and powerdown configuration bank
package pdc_pkg;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int NUM_CFG = 3;
	localparam int NUM_SEL = 4;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_LOOP_DIV = 8'h19;
	localparam logic [ADDR_W-1:0] IDX_POWERDOWN = 8'h1A;
	localparam logic [ADDR_W-1:0] IDX_REF_FUSE = 8'h1B;
	localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_LOOP_DIV = IDX_LOOP_DIV << 2;
	localparam logic [ADDR_W-1:0] ADDR_POWERDOWN = IDX_POWERDOWN << 2;
	localparam logic [ADDR_W-1:0] ADDR_REF_FUSE = IDX_REF_FUSE << 2;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = IDX_STATUS << 2;

	// One-hot select positions
	localparam int SEL_LOOP = 0;
	localparam int SEL_PWR = 1;
	localparam int SEL_REF = 2;
	localparam int SEL_STAT = 3;

	// Reset values and writable-bit masks
	localparam logic [REG_W-1:0] RST_LOOP_DIV = 16'h0440;
	localparam logic [REG_W-1:0] RST_POWERDOWN = 16'h0020;
	localparam logic [REG_W-1:0] RST_REF_FUSE = 16'h0000;
	localparam logic [REG_W-1:0] WM_LOOP_DIV = 16'hFFFC;
	localparam logic [REG_W-1:0] WM_POWERDOWN = 16'hFCFF;
	localparam logic [REG_W-1:0] WM_REF_FUSE = 16'h8800;
	localparam logic [REG_W-1:0] CFG_RESET [NUM_CFG] =
		'{RST_LOOP_DIV, RST_POWERDOWN, RST_REF_FUSE};
	localparam logic [REG_W-1:0] CFG_WMASK [NUM_CFG] =
		'{WM_LOOP_DIV, WM_POWERDOWN, WM_REF_FUSE};

	// Loop divider fields
	localparam int M_MSB = 15;
	localparam int M_LSB = 8;
	localparam int N_MSB = 7;
	localparam int N_LSB = 4;
	localparam int BTUNE_MSB = 3;
	localparam int BTUNE_LSB = 2;
	localparam logic [6:0] M_MIN_CODE = 7'h04;

	// Powerdown fields
	localparam int COARSE_MSB = 15;
	localparam int COARSE_LSB = 10;
	localparam int BIT_BIAS = 7;
	localparam int BIT_TSENSE = 6;
	localparam int BIT_SYNTH = 5;
	localparam int BIT_CLKRCV = 4;
	localparam int BIT_CHA = 3;
	localparam int BIT_CHB = 2;
	localparam int BIT_CHC = 1;
	localparam int BIT_CHD = 0;

	// Reference and fuse fields
	localparam int BIT_EXTREF = 15;
	localparam int BIT_FUSE = 11;

	// Status fields
	localparam int ST_LF_MSB = 2;
	localparam int ST_LF_LSB = 0;
	localparam int ST_LOCK = 3;
	localparam int ST_MVALID = 4;
	localparam logic [2:0] LF_LOCK_MIN = 3'h2;
	localparam logic [2:0] LF_LOCK_MAX = 3'h5;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: pdc_cfg_reg.sv
// One configuration word with byte lanes and protected reserved bits
module pdc_cfg_reg #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter logic [WIDTH-1:0] WRITE_MASK = '1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [WIDTH/8-1:0] be,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] lane_mask;
	logic [WIDTH-1:0] wmask;

	// Expand byte strobes to bit mask
	always_comb begin
		lane_mask = '0;
		for (int i = 0; i < WIDTH / 8; i++) begin
			lane_mask[i*8 +: 8] = {8{be[i]}};
		end
	end

	assign wmask = lane_mask & WRITE_MASK;

	// Reserved bits never take write data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RESET_VAL;
		end else if (we) begin
			q <= (q & ~wmask) | (wdata & wmask);
		end
	end

	property p_rsvd_hold;
		@(posedge aclk) disable iff (!aresetn)
		(q & ~WRITE_MASK) == (RESET_VAL & ~WRITE_MASK);
	endproperty
	a_rsvd_hold: assert property (p_rsvd_hold)
		else $error("reserved bits left their reset value");

endmodule

// File: pdc_div_decode.sv
// Decodes loop divider codes into divide ratios
module pdc_div_decode (
	input wire logic [7:0] m_code,
	input wire logic [3:0] n_code,
	output logic [7:0] m_value,
	output logic m_valid,
	output logic [4:0] n_value
);

	// Top code bit doubles the lower seven bits
	always_comb begin
		if (!m_code[7]) begin
			m_value = {1'b0, m_code[6:0]};
		end else begin
			m_value = {m_code[6:0], 1'b0};
		end
		m_valid = (m_code[6:0] >= pdc_pkg::M_MIN_CODE);
	end

	// Ratio is the code plus one
	assign n_value = {1'b0, n_code} + 5'h01;

endmodule

// File: pdc_top.sv
// AXI4-Lite bank for loop divider, powerdown and reference selection
module pdc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pdc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pdc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [pdc_pkg::DATA_W/8-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pdc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pdc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] loop_filter_volt,
	output logic [7:0] m_div_value,
	output logic m_div_code_valid,
	output logic [4:0] n_div_value,
	output logic [1:0] vco_bias_tune,
	output logic [5:0] vco_coarse_tune,
	output logic bias_sleep,
	output logic tsense_sleep,
	output logic synth_sleep,
	output logic clk_rcv_sleep,
	output logic sync_strobe_input_sleep,
	output logic chan_a_powerdown,
	output logic chan_b_powerdown,
	output logic chan_c_powerdown,
	output logic chan_d_powerdown,
	output logic ext_ref_sel,
	output logic fuse_sleep
);

	localparam int REG_W = pdc_pkg::REG_W;
	localparam int NUM_CFG = pdc_pkg::NUM_CFG;
	localparam int NUM_SEL = pdc_pkg::NUM_SEL;

	// Address to one-hot register select, shared by both paths
	function automatic logic [NUM_SEL-1:0] reg_decode(
		input logic [pdc_pkg::ADDR_W-1:0] a
	);
		logic [NUM_SEL-1:0] sel;
		sel = '0;
		sel[pdc_pkg::SEL_LOOP] = (a == pdc_pkg::ADDR_LOOP_DIV);
		sel[pdc_pkg::SEL_PWR] = (a == pdc_pkg::ADDR_POWERDOWN);
		sel[pdc_pkg::SEL_REF] = (a == pdc_pkg::ADDR_REF_FUSE);
		sel[pdc_pkg::SEL_STAT] = (a == pdc_pkg::ADDR_STATUS);
		return sel;
	endfunction

	logic aw_full_q;
	logic [pdc_pkg::ADDR_W-1:0] awaddr_q;
	logic w_full_q;
	logic [pdc_pkg::DATA_W-1:0] wdata_q;
	logic [pdc_pkg::DATA_W/8-1:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [pdc_pkg::DATA_W-1:0] rdata_q;
	logic [pdc_pkg::DATA_W-1:0] rdata_d;
	logic [NUM_SEL-1:0] wr_sel;
	logic [NUM_SEL-1:0] rd_sel;
	logic wr_fire;
	logic rd_fire;
	logic [REG_W-1:0] cfg_q [NUM_CFG];
	logic [REG_W-1:0] loop_word;
	logic [REG_W-1:0] pwr_word;
	logic [REG_W-1:0] ref_word;
	logic [REG_W-1:0] status_word;
	logic [7:0] m_value_d;
	logic m_valid_d;
	logic [4:0] n_value_d;
	logic [7:0] m_div_value_q;
	logic m_div_code_valid_q;
	logic [4:0] n_div_value_q;
	logic in_lock_range;

	// Protection bits are accepted and not used
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// Write commits only once address and data are both held
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_sel = reg_decode(awaddr_q);
	assign rd_sel = reg_decode(s_axi_araddr);

	// Write address holding stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_full_q <= 1'b0;
		end
	end

	// Write data holding stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_full_q <= 1'b0;
		end
	end

	// Write response; unmapped writes are dropped with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= pdc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (|wr_sel) ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Configuration words, each with its own reserved mask
	for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
		pdc_cfg_reg #(
			.WIDTH(REG_W),
			.RESET_VAL(pdc_pkg::CFG_RESET[i]),
			.WRITE_MASK(pdc_pkg::CFG_WMASK[i])
		) u_reg (
			.aclk(aclk),
			.aresetn(aresetn),
			.we(wr_fire && wr_sel[i]),
			.wdata(wdata_q[REG_W-1:0]),
			.be(wstrb_q[REG_W/8-1:0]),
			.q(cfg_q[i])
		);
	end

	assign loop_word = cfg_q[pdc_pkg::SEL_LOOP];
	assign pwr_word = cfg_q[pdc_pkg::SEL_PWR];
	assign ref_word = cfg_q[pdc_pkg::SEL_REF];

	// Lock window flag helps software walk the coarse tuning
	assign in_lock_range = (loop_filter_volt >= pdc_pkg::LF_LOCK_MIN) &&
		(loop_filter_volt <= pdc_pkg::LF_LOCK_MAX);

	// Read-only status view of the block
	always_comb begin
		status_word = '0;
		status_word[pdc_pkg::ST_LF_MSB:pdc_pkg::ST_LF_LSB] = loop_filter_volt;
		status_word[pdc_pkg::ST_LOCK] = in_lock_range;
		status_word[pdc_pkg::ST_MVALID] = m_div_code_valid_q;
	end

	// Read mux; upper half word always reads zero
	always_comb begin
		rdata_d = '0;
		unique case (1'b1)
			rd_sel[pdc_pkg::SEL_LOOP]: rdata_d[REG_W-1:0] = loop_word;
			rd_sel[pdc_pkg::SEL_PWR]: rdata_d[REG_W-1:0] = pwr_word;
			rd_sel[pdc_pkg::SEL_REF]: rdata_d[REG_W-1:0] = ref_word;
			rd_sel[pdc_pkg::SEL_STAT]: rdata_d[REG_W-1:0] = status_word;
			default: rdata_d = '0;
		endcase
	end

	// Read channel; one read outstanding at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= pdc_pkg::RESP_OKAY;
			rdata_q <= '0;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rresp_q <= (|rd_sel) ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
			rdata_q <= rdata_d;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	pdc_div_decode u_div (
		.m_code(loop_word[pdc_pkg::M_MSB:pdc_pkg::M_LSB]),
		.n_code(loop_word[pdc_pkg::N_MSB:pdc_pkg::N_LSB]),
		.m_value(m_value_d),
		.m_valid(m_valid_d),
		.n_value(n_value_d)
	);

	// Registered ratios; lag the register word by one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			m_div_value_q <= '0;
			m_div_code_valid_q <= 1'b0;
			n_div_value_q <= '0;
		end else begin
			m_div_value_q <= m_value_d;
			m_div_code_valid_q <= m_valid_d;
			n_div_value_q <= n_value_d;
		end
	end

	assign m_div_value = m_div_value_q;
	assign m_div_code_valid = m_div_code_valid_q;
	assign n_div_value = n_div_value_q;

	// Bias tuning passes through; normal value is software's job
	assign vco_bias_tune = loop_word[pdc_pkg::BTUNE_MSB:pdc_pkg::BTUNE_LSB];
	assign vco_coarse_tune = pwr_word[pdc_pkg::COARSE_MSB:pdc_pkg::COARSE_LSB];

	// Sleep controls straight from register flops
	assign bias_sleep = pwr_word[pdc_pkg::BIT_BIAS];
	assign tsense_sleep = pwr_word[pdc_pkg::BIT_TSENSE];
	assign synth_sleep = pwr_word[pdc_pkg::BIT_SYNTH];
	assign clk_rcv_sleep = pwr_word[pdc_pkg::BIT_CLKRCV];
	assign sync_strobe_input_sleep = pwr_word[pdc_pkg::BIT_CLKRCV];
	assign chan_a_powerdown = pwr_word[pdc_pkg::BIT_CHA];
	assign chan_b_powerdown = pwr_word[pdc_pkg::BIT_CHB];
	assign chan_c_powerdown = pwr_word[pdc_pkg::BIT_CHC];
	assign chan_d_powerdown = pwr_word[pdc_pkg::BIT_CHD];

	// Reference select and fuse sleep; fuses stay awake until written
	assign ext_ref_sel = ref_word[pdc_pkg::BIT_EXTREF];
	assign fuse_sleep = ref_word[pdc_pkg::BIT_FUSE];

	// Checks on the design's own behaviour
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Ratios lag reset release by one edge, so start only out of reset
	property p_m_direct;
		aresetn && !loop_word[pdc_pkg::M_MSB] |=>
			m_div_value == {1'b0, $past(loop_word[14:8])};
	endproperty
	a_m_direct: assert property (p_m_direct)
		else $error("direct M ratio wrong");

	property p_m_double;
		aresetn && loop_word[pdc_pkg::M_MSB] |=>
			m_div_value == {$past(loop_word[14:8]), 1'b0};
	endproperty
	a_m_double: assert property (p_m_double)
		else $error("doubled M ratio wrong");

	property p_m_invalid;
		(loop_word[14:8] < pdc_pkg::M_MIN_CODE) |=> !m_div_code_valid;
	endproperty
	a_m_invalid: assert property (p_m_invalid)
		else $error("invalid M code flagged valid");

	property p_n_ratio;
		aresetn |=> n_div_value == {1'b0, $past(loop_word[7:4])} + 5'h01;
	endproperty
	a_n_ratio: assert property (p_n_ratio)
		else $error("N ratio not code plus one");

	property p_loop_reset;
		$rose(aresetn) |-> loop_word == pdc_pkg::RST_LOOP_DIV;
	endproperty
	a_loop_reset: assert property (p_loop_reset)
		else $error("loop divider reset value wrong");

	property p_pwr_reset;
		$rose(aresetn) |-> pwr_word == pdc_pkg::RST_POWERDOWN && synth_sleep;
	endproperty
	a_pwr_reset: assert property (p_pwr_reset)
		else $error("powerdown reset value wrong");

	property p_bias_write;
		wr_fire && wr_sel[pdc_pkg::SEL_PWR] && wstrb_q[0] |=>
			bias_sleep == $past(wdata_q[7]) &&
			tsense_sleep == $past(wdata_q[6]);
	endproperty
	a_bias_write: assert property (p_bias_write)
		else $error("bias or sensor sleep missed a write");

	property p_sleep_write;
		wr_fire && wr_sel[pdc_pkg::SEL_PWR] && wstrb_q[0] |=>
			{synth_sleep, clk_rcv_sleep, chan_a_powerdown, chan_b_powerdown,
			chan_c_powerdown, chan_d_powerdown} == $past(wdata_q[5:0]);
	endproperty
	a_sleep_write: assert property (p_sleep_write)
		else $error("sleep bits missed a write");

	property p_strobe_pair;
		clk_rcv_sleep == sync_strobe_input_sleep;
	endproperty
	a_strobe_pair: assert property (p_strobe_pair)
		else $error("receiver sleeps disagree");

	property p_ref_write;
		wr_fire && wr_sel[pdc_pkg::SEL_REF] && wstrb_q[1] |=>
			ext_ref_sel == $past(wdata_q[15]) && fuse_sleep == $past(wdata_q[11]);
	endproperty
	a_ref_write: assert property (p_ref_write)
		else $error("reference word missed a write");

	property p_write_resp;
		aw_full_q && w_full_q && !bvalid_q |=> bvalid_q ##0 !aw_full_q;
	endproperty
	a_write_resp: assert property (p_write_resp)
		else $error("write response not one cycle after commit");

	c_write_pwr: cover property (wr_fire && wr_sel[pdc_pkg::SEL_PWR]);
	c_read_stat: cover property (rd_fire && rd_sel[pdc_pkg::SEL_STAT]);
	c_m_double: cover property (loop_word[pdc_pkg::M_MSB] && m_div_code_valid);
	c_unmapped: cover property (wr_fire && !(|wr_sel));

endmodule

// File: pdc_tb_top.sv
// Self-checking bench for the loop divider and powerdown register bank
module pdc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [2:0] lf_volt = 3'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] m_val;
	logic [4:0] n_val;
	logic m_ok, b_sl, t_sl, s_sl, c_sl, o_sl, ca, cb, cc, cd, ext, fuse;
	logic [1:0] btune;
	logic [5:0] coarse;
	int num_errors = 0;
	int comparisons = 0;

	// Free-running 40 MHz clock
	always #12.5 aclk = ~aclk;

	pdc_top i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.loop_filter_volt(lf_volt), .m_div_value(m_val),
		.m_div_code_valid(m_ok), .n_div_value(n_val),
		.vco_bias_tune(btune), .vco_coarse_tune(coarse),
		.bias_sleep(b_sl), .tsense_sleep(t_sl), .synth_sleep(s_sl),
		.clk_rcv_sleep(c_sl), .sync_strobe_input_sleep(o_sl),
		.chan_a_powerdown(ca), .chan_b_powerdown(cb),
		.chan_c_powerdown(cc), .chan_d_powerdown(cd),
		.ext_ref_sel(ext), .fuse_sleep(fuse)
	);

	// Compare and count; four-state equality so X matches only X
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h",
				$time, what, got, exp);
		end
	endtask

	// Single write; address and data released separately when taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] er);
		logic aw_done, w_done;
		int n;
		aw_done = 1'b0;
		w_done = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done) && n < 100) begin
			@(posedge aclk);
			n++;
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
			n++;
		end while (!bvalid && n < 100);
		if (n >= 100) begin
			num_errors++;
			$display("unexpected at %0t: write not answered", $time);
		end
		chk({30'h0, bresp}, {30'h0, er}, "write response");
		bready <= 1'b0;
	endtask

	// Single read; rready held until rvalid is sampled
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < 100);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!rvalid && n < 100);
		if (n >= 100) begin
			num_errors++;
			$display("unexpected at %0t: read not answered", $time);
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		// One edge gap so a following read never re-raises rready at once
		@(posedge aclk);
	endtask

	// Read a register and compare word and response
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
			input logic [1:0] er, input string what);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(a, d, r);
		chk(d, exp, what);
		chk({30'h0, r}, {30'h0, er}, "read response");
	endtask

	// Reset held for eight cycles, released just after an edge
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask

	task automatic test_reset();
		rd_chk(8'h64, 32'h0440, 2'h0, "loop reset");
		rd_chk(8'h68, 32'h0020, 2'h0, "powerdown reset");
		rd_chk(8'h6C, 32'h0000, 2'h0, "reference reset");
		chk({s_sl, b_sl, t_sl, c_sl, ca, ext, fuse}, 32'h40, "sleeps");
		chk({m_ok, m_val, n_val}, {1'b1, 8'd4, 5'd5}, "ratios");
		$display("test reset done");
	endtask

	// M and N codes across both M ranges and one invalid low code
	task automatic test_divider();
		logic [7:0] mc [5] = '{8'h7F, 8'h84, 8'hFF, 8'h03, 8'h04};
		logic [3:0] nc [5] = '{4'hF, 4'h0, 4'h7, 4'h2, 4'h1};
		logic [7:0] me [5] = '{8'd127, 8'd8, 8'd254, 8'd3, 8'd4};
		logic [4:0] ne [5] = '{5'd16, 5'd1, 5'd8, 5'd3, 5'd2};
		logic ve [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			axi_write(8'h64, {16'h0, mc[i], nc[i], 4'h7}, 4'hF, 2'h0);
			@(posedge aclk);
			chk(m_val, me[i], "m ratio");
			chk(n_val, ne[i], "n ratio");
			chk(m_ok, ve[i], "m code valid");
			chk(btune, 2'h1, "bias tune");
			rd_chk(8'h64, {mc[i], nc[i], 4'h4}, 2'h0, "loop readback");
		end
		axi_write(8'h64, 32'hFFFF_1234, 4'h2, 2'h0);
		rd_chk(8'h64, 32'h1214, 2'h0, "upper lane only");
		$display("test divider done");
	endtask

	// Walk one sleep bit at a time with a coarse tune value
	task automatic test_sleep();
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = 8'h01 << i;
			axi_write(8'h68, {16'h0, 6'h2A, 2'h3, v}, 4'hF, 2'h0);
			@(posedge aclk);
			chk({b_sl, t_sl, s_sl, c_sl, o_sl, ca, cb, cc, cd},
				{v[7:4], v[4], v[3:0]}, "sleep outputs");
			chk(coarse, 6'h2A, "coarse tune");
			rd_chk(8'h68, {16'hA8, v}, 2'h0, "powerdown readback");
		end
		$display("test sleep done");
	endtask

	task automatic test_reference();
		axi_write(8'h6C, 32'hFFFF, 4'hF, 2'h0);
		@(posedge aclk);
		chk({ext, fuse}, 2'h3, "reference outputs");
		rd_chk(8'h6C, 32'h8800, 2'h0, "reference readback");
		axi_write(8'h6C, 32'h0800, 4'hF, 2'h0);
		@(posedge aclk);
		chk({ext, fuse}, 2'h1, "internal reference");
		$display("test reference done");
	endtask

	// Unmapped place refused; status reports lock window
	task automatic test_misc();
		axi_write(8'h80, 32'hFFFF, 4'hF, 2'h2);
		rd_chk(8'h80, 32'h0, 2'h2, "unmapped read");
		for (int i = 0; i < 8; i++) begin
			lf_volt <= 3'(i);
			@(posedge aclk);
			rd_chk(8'h70, {27'h0, 1'b1, (i >= 2 && i <= 5), 3'(i)}, 2'h0,
				"status");
		end
		do_reset();
		chk({s_sl, b_sl, ext}, 3'h4, "second reset");
		rd_chk(8'h64, 32'h0440, 2'h0, "loop after reset");
		$display("test misc done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		do_reset();
		test_reset();
		test_divider();
		test_sleep();
		test_reference();
		test_misc();
		complete_run();
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#(25ns * 20000);
		num_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule
